// ==== logic/pad_output_driver_control_regs.sv ====
// Pad output driver control bank: APB slave with ten control words.
// Assumes a 32-bit APB master; pad analog cells consume the field outputs.
// What this block does
// - Each four-pad nibble has a two-bit edge-rate select field.
// - Each nibble also has a separate two-bit drive-strength select.
// - Edge code 01 is slow edges near 60 ns; 10 reserved.
// - Drive 00 high, 01 dynamic, 10 low current.
// - Eight-bit port registers read zero in bits 15 to 8.
// - Each register governs one fixed port, two or four nibbles.
// - Nibble index runs 0 to 3; 3 is top of 16-bit port.
`timescale 1ns/1ns
`default_nettype none
module pad_output_driver_control_regs
   import pad_ctrl_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Edge and drive selects, two bits per nibble, nibble 0 lowest
   output logic [2*NIBBLES_NARROW-1:0] port0_low_edge,
   output logic [2*NIBBLES_NARROW-1:0] port0_low_drive,
   output logic [2*NIBBLES_NARROW-1:0] port0_high_edge,
   output logic [2*NIBBLES_NARROW-1:0] port0_high_drive,
   output logic [2*NIBBLES_NARROW-1:0] port1_low_edge,
   output logic [2*NIBBLES_NARROW-1:0] port1_low_drive,
   output logic [2*NIBBLES_NARROW-1:0] port1_high_edge,
   output logic [2*NIBBLES_NARROW-1:0] port1_high_drive,
   output logic [2*NIBBLES_WIDE-1:0] port2_edge,
   output logic [2*NIBBLES_WIDE-1:0] port2_drive,
   output logic [2*NIBBLES_WIDE-1:0] port3_edge,
   output logic [2*NIBBLES_WIDE-1:0] port3_drive,
   output logic [2*NIBBLES_NARROW-1:0] port4_edge,
   output logic [2*NIBBLES_NARROW-1:0] port4_drive,
   output logic [2*NIBBLES_NARROW-1:0] port6_edge,
   output logic [2*NIBBLES_NARROW-1:0] port6_drive,
   output logic [2*NIBBLES_NARROW-1:0] port7_edge,
   output logic [2*NIBBLES_NARROW-1:0] port7_drive,
   output logic [2*NIBBLES_NARROW-1:0] port8_edge,
   output logic [2*NIBBLES_NARROW-1:0] port8_drive
);
   // ==========================================================
   // Address decode
   logic [NUM_REGS-1:0] hit;
   logic any_hit;
   logic setup;
   logic [15:0] value [NUM_REGS];
   logic [2*NIBBLES_WIDE-1:0] edge_all [NUM_REGS];
   logic [2*NIBBLES_WIDE-1:0] drive_all [NUM_REGS];
   logic [31:0] rd_next;
   logic [31:0] prdata_reg;
   logic pslverr_reg;
   logic pready_reg;
   // Low half-word written only when both low lanes are enabled
   logic lanes_ok;

   assign setup = psel && !penable;
   assign lanes_ok = pstrb[0] && pstrb[1];

   always_comb begin
      hit = '0;
      for (int i = 0; i < NUM_REGS; i++) begin
         hit[i] = (paddr[31:0] == {14'h0, REG_INDEX[i], 2'b00});
      end
      any_hit = |hit;
   end

   // ==========================================================
   // Control words, one per port, two each (low and high) for ports 0 and 1
   genvar r;
   generate
      for (r = 0; r < NUM_REGS; r++) begin : g_reg
         localparam int NIB = WIDE_PORT_MASK[r] ? NIBBLES_WIDE
                                                 : NIBBLES_NARROW;
         logic [2*NIB-1:0] e_sel;
         logic [2*NIB-1:0] d_sel;
         pad_ctrl_word #(.NIBBLES(NIB)) u_word (
            .pclk(pclk),
            .presetn(presetn),
            .clk_en(clk_en),
            .wr_en(setup && pwrite && hit[r] && lanes_ok),
            .wr_data(pwdata[15:0]),
            .value(value[r]),
            .edge_sel(e_sel),
            .drive_sel(d_sel)
         );
         always_comb begin
            edge_all[r] = '0;
            drive_all[r] = '0;
            edge_all[r][2*NIB-1:0] = e_sel;
            drive_all[r][2*NIB-1:0] = d_sel;
         end
      end
   endgenerate

   // ==========================================================
   // Read data and response, captured in setup, shown in access
   always_comb begin
      rd_next = 32'h0000_0000;
      for (int i = 0; i < NUM_REGS; i++) begin
         if (hit[i]) begin
            rd_next = {16'h0000, value[i]};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (clk_en && setup) begin
         prdata_reg <= pwrite ? 32'h0000_0000 : rd_next;
         pslverr_reg <= !any_hit;
      end
   end

   // Ready follows a setup cycle taken with clk_en high, so such an access has one wait-free phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
      end else if (clk_en) begin
         pready_reg <= setup;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg && pready_reg;

   // ==========================================================
   // Pad field outputs; codes follow edge_rate_t and drive_strength_t
   assign port0_low_edge = edge_all[0][2*NIBBLES_NARROW-1:0];
   assign port0_low_drive = drive_all[0][2*NIBBLES_NARROW-1:0];
   assign port0_high_edge = edge_all[1][2*NIBBLES_NARROW-1:0];
   assign port0_high_drive = drive_all[1][2*NIBBLES_NARROW-1:0];
   assign port1_low_edge = edge_all[2][2*NIBBLES_NARROW-1:0];
   assign port1_low_drive = drive_all[2][2*NIBBLES_NARROW-1:0];
   assign port1_high_edge = edge_all[3][2*NIBBLES_NARROW-1:0];
   assign port1_high_drive = drive_all[3][2*NIBBLES_NARROW-1:0];
   assign port2_edge = edge_all[4];
   assign port2_drive = drive_all[4];
   assign port3_edge = edge_all[5];
   assign port3_drive = drive_all[5];
   assign port4_edge = edge_all[6][2*NIBBLES_NARROW-1:0];
   assign port4_drive = drive_all[6][2*NIBBLES_NARROW-1:0];
   assign port6_edge = edge_all[7][2*NIBBLES_NARROW-1:0];
   assign port6_drive = drive_all[7][2*NIBBLES_NARROW-1:0];
   assign port7_edge = edge_all[8][2*NIBBLES_NARROW-1:0];
   assign port7_drive = drive_all[8][2*NIBBLES_NARROW-1:0];
   assign port8_edge = edge_all[9][2*NIBBLES_NARROW-1:0];
   assign port8_drive = drive_all[9][2*NIBBLES_NARROW-1:0];
endmodule
`default_nettype wire

// ==== logic/pad_ctrl_pkg.sv ====
// Package: offsets, field layout and codes for the pad output control bank.
// Assumes a 32-bit APB slave; each register is one aligned word.
package pad_ctrl_pkg;
   // ==========================================================
   // Register map (register indices; the full paddr must equal 4 x index)
   localparam int NUM_REGS = 10;
   localparam logic [15:0] PORT0_LOW_PAD_CTRL_OFFS = 16'hF080;
   localparam logic [15:0] PORT0_HIGH_PAD_CTRL_OFFS = 16'hF082;
   localparam logic [15:0] PORT1_LOW_PAD_CTRL_OFFS = 16'hF084;
   localparam logic [15:0] PORT1_HIGH_PAD_CTRL_OFFS = 16'hF086;
   localparam logic [15:0] PORT2_PAD_CTRL_OFFS = 16'hF088;
   localparam logic [15:0] PORT3_PAD_CTRL_OFFS = 16'hF08A;
   localparam logic [15:0] PORT4_PAD_CTRL_OFFS = 16'hF08C;
   localparam logic [15:0] PORT6_PAD_CTRL_OFFS = 16'hF08E;
   localparam logic [15:0] PORT7_PAD_CTRL_OFFS = 16'hF090;
   localparam logic [15:0] PORT8_PAD_CTRL_OFFS = 16'hF092;
   // Offsets are register indices: byte address = 4 x index
   localparam logic [15:0] REG_INDEX [NUM_REGS] = '{
      PORT0_LOW_PAD_CTRL_OFFS, PORT0_HIGH_PAD_CTRL_OFFS,
      PORT1_LOW_PAD_CTRL_OFFS, PORT1_HIGH_PAD_CTRL_OFFS,
      PORT2_PAD_CTRL_OFFS, PORT3_PAD_CTRL_OFFS,
      PORT4_PAD_CTRL_OFFS, PORT6_PAD_CTRL_OFFS,
      PORT7_PAD_CTRL_OFFS, PORT8_PAD_CTRL_OFFS};
   // Registers 4 and 5 serve the 16-bit ports
   localparam logic [NUM_REGS-1:0] WIDE_PORT_MASK = 10'h030;
   // ==========================================================
   // Field layout
   localparam int NIBBLES_WIDE = 4;
   localparam int NIBBLES_NARROW = 2;
   localparam int NIBBLE_BITS = 4;
   localparam int EDGE_POS = 0;
   localparam int DRIVE_POS = 2;
   localparam int FIELD_W = 2;
   localparam logic [15:0] PAD_CTRL_RESET = 16'h0000;
   localparam logic [15:0] NARROW_MASK = 16'h00FF;
   // ==========================================================
   // Encodings
   typedef enum logic [1:0] {
      EDGE_FAST = 2'h0,
      EDGE_SLOW = 2'h1,
      EDGE_RSVD2 = 2'h2,
      EDGE_RSVD3 = 2'h3
   } edge_rate_t;
   typedef enum logic [1:0] {
      DRIVE_HIGH = 2'h0,
      DRIVE_DYNAMIC = 2'h1,
      DRIVE_LOW = 2'h2,
      DRIVE_RSVD = 2'h3
   } drive_strength_t;
   localparam int SLOW_EDGE_NS = 60;
endpackage

// ==== logic/pad_ctrl_word.sv ====
// One pad output control word with nibble field decode.
// Assumes write strobe and data already qualified by the bus slave.
`timescale 1ns/1ns
`default_nettype none
module pad_ctrl_word
   import pad_ctrl_pkg::*;
#(
   parameter int NIBBLES = NIBBLES_WIDE
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic wr_en,
   input wire logic [15:0] wr_data,
   output logic [15:0] value,
   output logic [2*NIBBLES-1:0] edge_sel,
   output logic [2*NIBBLES-1:0] drive_sel
);
   localparam int W = NIBBLES * NIBBLE_BITS;
   logic [W-1:0] word_reg;

   // ==========================================================
   // Storage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word_reg <= PAD_CTRL_RESET[W-1:0];
      end else if (clk_en && wr_en) begin
         word_reg <= wr_data[W-1:0];
      end
   end

   // Unimplemented upper nibbles read as zero
   always_comb begin
      value = 16'h0000;
      value[W-1:0] = word_reg;
   end

   // ==========================================================
   // Per-nibble field split
   genvar n;
   generate
      for (n = 0; n < NIBBLES; n++) begin : g_nib
         assign edge_sel[2*n +: FIELD_W] =
            word_reg[NIBBLE_BITS*n + EDGE_POS +: FIELD_W];
         assign drive_sel[2*n +: FIELD_W] =
            word_reg[NIBBLE_BITS*n + DRIVE_POS +: FIELD_W];
      end
   endgenerate
endmodule
`default_nettype wire

// ==== sim/pad_ctrl_assertions.sv ====
// Checker: bus timing and field layout of the pad control bank.
// Assumes it is bound to the bank and sees only the bank's ports.
`timescale 1ns/1ns
`default_nettype none
module pad_ctrl_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [3:0] port0_low_edge,
   input wire logic [3:0] port0_low_drive,
   input wire logic [7:0] port2_edge
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ============================================================
   // Bus phases
   sequence s_setup;
      psel && !penable && clk_en;
   endsequence
   sequence s_wr_full;
      s_setup ##0 (pwrite && pstrb[1:0] == 2'h3);
   endsequence
   a_ready_next: assert property (s_setup |=> pready)
      else $error("no ready after setup");
   a_ready_pulse: assert property (pready && clk_en |=> !pready)
      else $error("ready held too long");
   a_err_unmapped: assert property (s_setup ##0 paddr == 32'h0003C24C
      |=> pready && pslverr) else $error("no error on unmapped");
   a_ok_mapped: assert property (s_setup ##0 paddr == 32'h0003C220
      |=> !pslverr) else $error("error on mapped word");
   a_upper_zero: assert property (pready
      |-> prdata[31:16] == 16'h0000) else $error("upper read bits set");
   a_narrow_read: assert property (s_setup ##0 !pwrite ##0
      paddr == 32'h0003C200 |=> prdata == {24'h000000, port0_low_drive[3:2],
      port0_low_edge[3:2], port0_low_drive[1:0], port0_low_edge[1:0]})
      else $error("narrow read mismatch");
   a_drive_write: assert property (s_wr_full
      ##0 paddr == 32'h0003C200 |=> port0_low_drive ==
      {$past(pwdata[7:6]), $past(pwdata[3:2])})
      else $error("drive field misplaced");
   a_wide_write: assert property (s_wr_full
      ##0 paddr == 32'h0003C220 |=> port2_edge == {$past(pwdata[13:12]),
      $past(pwdata[9:8]), $past(pwdata[5:4]), $past(pwdata[1:0])})
      else $error("edge field misplaced");
   a_no_strobe: assert property (s_setup ##0 pwrite ##0 pstrb[1:0] != 2'h3
      |=> $stable(port2_edge)) else $error("write without strobes");
endmodule
bind pad_output_driver_control_regs pad_ctrl_assertions pad_ctrl_assertions_i
   (.*);
`default_nettype wire

// ==== sim/pad_output_driver_control_regs_bench.sv ====
// Bench: APB-driven self-checking tests of the pad control bank.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
   num_errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module pad_output_driver_control_regs_bench import pad_ctrl_pkg::*;;
   logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
   logic [3:0] pstrb = '0;
   logic pready, pslverr, er;
   logic [3:0] port0_low_edge, port0_low_drive, port0_high_edge;
   logic [3:0] port0_high_drive, port1_low_edge, port1_low_drive;
   logic [3:0] port1_high_edge, port1_high_drive, port4_edge, port4_drive;
   logic [3:0] port6_edge, port6_drive, port7_edge, port7_drive;
   logic [3:0] port8_edge, port8_drive;
   logic [7:0] port2_edge, port2_drive, port3_edge, port3_drive;
   int num_errors = 0, compares = 0, cyc = 0;
   pad_output_driver_control_regs pad_output_driver_control_regs_i (.*);
   always #5 pclk = ~pclk;
   // ============================================================
   // Bus helpers
   function automatic logic [31:0] ad(int i);
      return {14'h0, REG_INDEX[i], 2'h0};
   endfunction
   task automatic apb(input logic w, input logic [31:0] a, d,
      input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input int i, input logic [15:0] e);
      apb(1'b0, ad(i), 32'h0, 4'h0);
      `CHK("read", {16'h0000, e}, rd)
      `CHK("rd_err", 1'b0, er)
   endtask
   // ============================================================
   // Scenarios
   task automatic t_reset();
      for (int i = 0; i < NUM_REGS; i++) rd_chk(i, 16'h0000);
      `CHK("p2_edge", 8'h00, port2_edge)
   endtask
   task automatic t_narrow();
      apb(1'b1, ad(0), 32'hFFFFA5C6, 4'hF);
      `CHK("p0l_edge", 4'h2, port0_low_edge)
      `CHK("p0l_drive", 4'hD, port0_low_drive)
      rd_chk(0, 16'h00C6);
   endtask
   task automatic t_wide();
      apb(1'b1, ad(4), 32'h00001B4E, 4'h3);
      `CHK("p2_edge", 8'h72, port2_edge)
      `CHK("p2_drive", 8'h27, port2_drive)
      rd_chk(4, 16'h1B4E);
   endtask
   task automatic t_all();
      logic [15:0] v;
      for (int i = 0; i < NUM_REGS; i++)
         apb(1'b1, ad(i), {16'h0000, {4{4'(i + 1)}}}, 4'hF);
      for (int i = 0; i < NUM_REGS; i++) begin
         v = {4{4'(i + 1)}};
         rd_chk(i, WIDE_PORT_MASK[i] ? v : v & NARROW_MASK);
      end
      `CHK("p3_edge", 8'hAA, port3_edge)
      `CHK("p3_drive", 8'h55, port3_drive)
      `CHK("p8_edge", 4'hA, port8_edge)
      `CHK("p8_drive", 4'hA, port8_drive)
      `CHK("p0l_edge", 4'h5, port0_low_edge)
      `CHK("p0l_drive", 4'h0, port0_low_drive)
      `CHK("p0h_edge", 4'hA, port0_high_edge)
      `CHK("p0h_drive", 4'h0, port0_high_drive)
      `CHK("p1l_edge", 4'hF, port1_low_edge)
      `CHK("p1l_drive", 4'h0, port1_low_drive)
      `CHK("p1h_edge", 4'h0, port1_high_edge)
      `CHK("p1h_drive", 4'h5, port1_high_drive)
      `CHK("p2_edge", 8'h55, port2_edge)
      `CHK("p2_drive", 8'h55, port2_drive)
      `CHK("p4_edge", 4'hF, port4_edge)
      `CHK("p4_drive", 4'h5, port4_drive)
      `CHK("p6_edge", 4'h0, port6_edge)
      `CHK("p6_drive", 4'hA, port6_drive)
      `CHK("p7_edge", 4'h5, port7_edge)
      `CHK("p7_drive", 4'hA, port7_drive)
   endtask
   task automatic t_refuse();
      apb(1'b0, 32'h0003C24C, 32'h0, 4'h0);
      `CHK("bad_err", 1'b1, er)
      `CHK("bad_data", 32'h0, rd)
      // Strobes on the upper lanes only must not reach the word
      apb(1'b1, ad(4), 32'h00000000, 4'hC);
      rd_chk(4, 16'h5555);
   endtask
   task automatic t_freeze();
      // Setup held while the clock enable is low must not be taken
      @(posedge pclk);
      clk_en <= 1'b0;
      psel <= 1'b1;
      pwrite <= 1'b1;
      paddr <= ad(6);
      pwdata <= 32'h0000_0000;
      pstrb <= 4'hF;
      repeat (3) @(posedge pclk);
      `CHK("frz_edge", 4'hF, port4_edge)
      `CHK("frz_ready", 1'b0, pready)
      clk_en <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      // Address lines on this port: fast edges, full current
      `CHK("p4_fast", 4'h0, port4_edge)
      `CHK("p4_high", 4'h0, port4_drive)
   endtask
   task automatic tally_and_finish();
      if (num_errors == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 2000) begin
         num_errors++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_narrow();
      t_wide();
      t_all();
      t_refuse();
      t_freeze();
      tally_and_finish();
   end
endmodule
`default_nettype wire
